/* File: src/spl_map.vh */
`ifndef SPL_MAP_VH
`define SPL_MAP_VH

// ------------------------------------------------------------
// Command opcodes
// ------------------------------------------------------------
`define SPL_OP_RD_PROT       8'h3C
`define SPL_OP_PROT_SECT     8'h36
`define SPL_OP_UNPROT_SECT   8'h39
`define SPL_OP_WR_STATUS     8'h01
`define SPL_OP_RD_STATUS     8'h05

// ------------------------------------------------------------
// Frame counts
// ------------------------------------------------------------
`define SPL_BYTE_LAST        5'h07
`define SPL_ADDR_LAST        5'h17

// ------------------------------------------------------------
// Address and status field positions
// ------------------------------------------------------------
`define SPL_SECT_MSB         17
`define SPL_SECT_LSB         16
`define SPL_ST_LOCK_BIT      7
`define SPL_ST_GLOB_MSB      5
`define SPL_ST_GLOB_LSB      2
`define SPL_GLOB_CLEAR       4'h0
`define SPL_GLOB_SET         4'hF

// ------------------------------------------------------------
// Summary encodings
// ------------------------------------------------------------
`define SPL_SUM_NONE         2'h0
`define SPL_SUM_SOME         2'h1
`define SPL_SUM_ALL          2'h3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SPL_RST_PROT         4'hF
`define SPL_RST_LOCK         1'b0
`define SPL_RST_PINS         4'hF

`endif

/* File: src/spl_sync.v */
`timescale 1ns/1ps
`include "spl_map.vh"

// ------------------------------------------------------------
// Two-stage pin synchroniser
// ------------------------------------------------------------
module spl_sync #(
   parameter W = 4
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] pinIn,
   output reg  [W-1:0] pinSync
);

   reg [W-1:0] meta_r;

   // First stage feeds only the second stage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r  <= `SPL_RST_PINS;
         pinSync <= `SPL_RST_PINS;
      end else begin
         meta_r  <= pinIn;
         pinSync <= meta_r;
      end
   end

endmodule

/* File: src/spl_prot_regs.v */
`timescale 1ns/1ps
`include "spl_map.vh"

// ------------------------------------------------------------
// Four sector protection bits
// ------------------------------------------------------------
module spl_prot_regs (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       setAll,
   input  wire       clrAll,
   input  wire       setOne,
   input  wire       clrOne,
   input  wire [1:0] sel,
   output reg  [3:0] prot_r
);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_r <= `SPL_RST_PROT;
      end else if (setAll) begin
         prot_r <= 4'hF;
      end else if (clrAll) begin
         prot_r <= 4'h0;
      end else if (setOne) begin
         prot_r[sel] <= 1'b1;
      end else if (clrOne) begin
         prot_r[sel] <= 1'b0;
      end
   end

endmodule

/* File: src/spl_sector_lock.v */
`timescale 1ns/1ps
`include "spl_map.vh"


module spl_sector_lock (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       csN,
   input  wire       sclk,
   input  wire       si,
   input  wire       wpN,
   output reg        so,
   output reg        soOe,
   output reg        protLockBit,
   output wire [3:0] sectorProtect,
   output reg  [1:0] sectorProtectSummary,
   output reg        hwLocked,
   output reg        swLocked
);

   // ---------------------------------------------------------
   // States and commands
   // ---------------------------------------------------------
   localparam ST_OPC  = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_WRSR = 3'h2;
   localparam ST_OUT  = 3'h3;
   localparam ST_SKIP = 3'h4;

   localparam CMD_RDP  = 2'h0;
   localparam CMD_PROT = 2'h1;
   localparam CMD_UNPR = 2'h2;
   localparam CMD_RDSR = 2'h3;

   // ---------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------
   // Shared by the status byte and the summary port
   function [1:0] summ;
      input [3:0] p;
      begin
         if (p == 4'hF)
            summ = `SPL_SUM_ALL;
         else if (p == 4'h0)
            summ = `SPL_SUM_NONE;
         else
            summ = `SPL_SUM_SOME;
      end
   endfunction

   // ---------------------------------------------------------
   // Pin synchronisation and edge detection
   // ---------------------------------------------------------
   wire [3:0] pinSync;
   wire       csS;
   wire       sclkS;
   wire       siS;
   wire       wpS;
   reg        sclkPrev_r;
   wire       sclkRise;
   wire       sclkFall;

   // Pins are asynchronous; nothing reads them raw
   spl_sync #(
      .W (4)
   ) u_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .pinIn   ({csN, sclk, si, wpN}),
      .pinSync (pinSync)
   );

   assign csS      = pinSync[3];
   assign sclkS    = pinSync[2];
   assign siS      = pinSync[1];
   assign wpS      = pinSync[0];
   // Edges count only while selected
   assign sclkRise = sclkS & ~sclkPrev_r & ~csS;
   assign sclkFall = ~sclkS & sclkPrev_r & ~csS;

   // ---------------------------------------------------------
   // Frame state
   // ---------------------------------------------------------
   reg  [2:0]  state_r;
   reg  [1:0]  cmd_r;
   reg  [4:0]  cnt_r;
   reg  [7:0]  shift_r;
   reg  [23:0] addr_r;
   reg  [7:0]  outByte_r;
   reg  [2:0]  outIdx_r;
   reg         setAll_r;
   reg         clrAll_r;
   reg         setOne_r;
   reg         clrOne_r;
   reg  [1:0]  sel_r;
   wire [7:0]  shift_nxt;
   wire [23:0] addr_nxt;
   wire [1:0]  sel_nxt;
   wire [3:0]  globField;
   wire        hwLock_nxt;
   wire [7:0]  statusByte;

   assign shift_nxt  = {shift_r[6:0], siS};
   assign addr_nxt   = {addr_r[22:0], siS};
   assign sel_nxt    = addr_nxt[`SPL_SECT_MSB:`SPL_SECT_LSB];
   assign globField  = shift_nxt[`SPL_ST_GLOB_MSB:`SPL_ST_GLOB_LSB];
   // Synced pin only; a raw level could split the decision
   assign hwLock_nxt = ~wpS & protLockBit;
   // Bits 5..2 read back summary, pin and a zero, not what was written
   assign statusByte = {protLockBit, 1'b0, summ(sectorProtect),
                        wpS, 1'b0, 2'h0};

   // Updates land one clk after the decode
   spl_prot_regs u_prot (
      .clk    (clk),
      .rst_n  (rst_n),
      .setAll (setAll_r),
      .clrAll (clrAll_r),
      .setOne (setOne_r),
      .clrOne (clrOne_r),
      .sel    (sel_r),
      .prot_r (sectorProtect)
   );

   // ---------------------------------------------------------
   // Command decode and protection updates
   // ---------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclkPrev_r  <= 1'b1;
         state_r     <= ST_OPC;
         cmd_r       <= CMD_RDP;
         cnt_r       <= 5'h00;
         shift_r     <= 8'h00;
         addr_r      <= 24'h000000;
         outByte_r   <= 8'h00;
         setAll_r    <= 1'b0;
         clrAll_r    <= 1'b0;
         setOne_r    <= 1'b0;
         clrOne_r    <= 1'b0;
         sel_r       <= 2'h0;
         protLockBit <= `SPL_RST_LOCK;
      end else begin
         sclkPrev_r <= sclkS;
         setAll_r   <= 1'b0;
         clrAll_r   <= 1'b0;
         setOne_r   <= 1'b0;
         clrOne_r   <= 1'b0;
         if (csS) begin
            // Release may come mid-byte; nothing is committed
            state_r <= ST_OPC;
            cnt_r   <= 5'h00;
         end else if (sclkRise) begin
            shift_r <= shift_nxt;
            addr_r  <= addr_nxt;
            cnt_r   <= cnt_r + 5'h01;
            case (state_r)
               ST_OPC: begin
                  if (cnt_r == `SPL_BYTE_LAST) begin
                     cnt_r <= 5'h00;
                     case (shift_nxt)
                        `SPL_OP_RD_PROT: begin
                           cmd_r   <= CMD_RDP;
                           state_r <= ST_ADDR;
                        end
                        `SPL_OP_PROT_SECT: begin
                           cmd_r   <= CMD_PROT;
                           state_r <= ST_ADDR;
                        end
                        `SPL_OP_UNPROT_SECT: begin
                           cmd_r   <= CMD_UNPR;
                           state_r <= ST_ADDR;
                        end
                        `SPL_OP_WR_STATUS: begin
                           state_r <= ST_WRSR;
                        end
                        `SPL_OP_RD_STATUS: begin
                           cmd_r     <= CMD_RDSR;
                           outByte_r <= statusByte;
                           state_r   <= ST_OUT;
                        end
                        default: begin
                           state_r <= ST_SKIP;
                        end
                     endcase
                  end
               end
               ST_ADDR: begin
                  if (cnt_r == `SPL_ADDR_LAST) begin
                     state_r <= ST_SKIP;
                     sel_r   <= sel_nxt;
                     if (cmd_r == CMD_RDP) begin
                        // Only the register bit, never the pin
                        outByte_r <=
                           {8{sectorProtect[sel_nxt]}};
                        state_r   <= ST_OUT;
                     end else if (!protLockBit) begin
                        // Any lock state ignores single-sector changes
                        setOne_r <= (cmd_r == CMD_PROT);
                        clrOne_r <= (cmd_r == CMD_UNPR);
                     end
                  end
               end
               ST_WRSR: begin
                  if (cnt_r == `SPL_BYTE_LAST) begin
                     state_r <= ST_SKIP;
                     // Old lock value decides; clearing it never
                     // fires a global op in the same write
                     if (hwLock_nxt) begin
                        protLockBit <= protLockBit;
                     end else if (protLockBit) begin
                        // Soft lock: bit may clear, no global op
                        protLockBit <=
                           shift_nxt[`SPL_ST_LOCK_BIT];
                     end else begin
                        protLockBit <=
                           shift_nxt[`SPL_ST_LOCK_BIT];
                        clrAll_r <=
                           (globField == `SPL_GLOB_CLEAR);
                        setAll_r <= (globField == `SPL_GLOB_SET);
                     end
                  end
               end
               ST_OUT: begin
                  cnt_r <= 5'h00;
               end
               ST_SKIP: begin
                  cnt_r <= 5'h00;
               end
               default: begin
                  state_r <= ST_SKIP;
               end
            endcase
         end else if (sclkFall && state_r == ST_OUT) begin
            // Status read refreshes on each byte boundary
            if (cmd_r == CMD_RDSR && outIdx_r == 3'h7)
               outByte_r <= statusByte;
         end
      end
   end

   // ---------------------------------------------------------
   // Serial output
   // ---------------------------------------------------------
   // So moves 2..3 clk after the pin falls; the host
   // samples on the next rise, well clear of it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         so       <= 1'b0;
         soOe     <= 1'b0;
         outIdx_r <= 3'h0;
      end else if (csS) begin
         soOe     <= 1'b0;
         so       <= 1'b0;
         outIdx_r <= 3'h0;
      end else if (sclkFall && state_r == ST_OUT) begin
         soOe     <= 1'b1;
         so       <= outByte_r[~outIdx_r];
         outIdx_r <= outIdx_r + 3'h1;
      end
   end

   // ---------------------------------------------------------
   // Lock state and summary outputs
   // ---------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hwLocked             <= 1'b0;
         swLocked             <= 1'b0;
         sectorProtectSummary <= `SPL_SUM_ALL;
      end else begin
         // Registered, so the lock flags trail the pins by 3 clk
         hwLocked             <= hwLock_nxt;
         swLocked             <= wpS & protLockBit;
         sectorProtectSummary <= summ(sectorProtect);
      end
   end

endmodule

/* File: testbench/spl_sector_lock_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Lock state, summary and serial output checks
// ----------------------------------------
module spl_sector_lock_assertions (
   input wire       clk,
   input wire       rst_n,
   input wire       csN,
   input wire       sclk,
   input wire       si,
   input wire       wpN,
   input wire       so,
   input wire       soOe,
   input wire       protLockBit,
   input wire [3:0] sectorProtect,
   input wire [1:0] sectorProtectSummary,
   input wire       hwLocked,
   input wire       swLocked
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_vals: assert property (
      $rose(rst_n) |-> sectorProtect == 4'hF && !protLockBit)
      else $error("bad reset state");
   a_hw_lock: assert property (
      (!wpN && protLockBit) [*4] |-> hwLocked && !swLocked)
      else $error("hw lock missing");
   a_sw_lock: assert property (
      (wpN && protLockBit) [*4] |-> swLocked && !hwLocked)
      else $error("sw lock missing");
   a_no_lock: assert property (
      !protLockBit [*4] |-> !hwLocked && !swLocked)
      else $error("stray lock");
   // Four cycles of margin cover the pin synchroniser
   a_hw_freeze: assert property (
      (!wpN && protLockBit) [*4] |=> protLockBit && $stable(sectorProtect))
      else $error("hw lock broken");
   a_sw_freeze: assert property (
      protLockBit [*3] |-> $stable(sectorProtect))
      else $error("locked bits moved");
   a_sum_code: assert property (
      ##1 sectorProtectSummary ==
         {&$past(sectorProtect), |$past(sectorProtect)})
      else $error("bad summary");
   a_oe_off: assert property (
      csN [*4] |-> !soOe && !so)
      else $error("so not released");
   a_so_hold: assert property (
      sclk [*4] |=> $stable(so))
      else $error("so moved on high sclk");
endmodule

/* File: testbench/spl_spi_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Mode 0 host, 4 clk per sclk phase
// ----------------------------------------
module spl_spi_host (
   input  wire clk,
   input  wire so,
   output reg  csN,
   output reg  sclk,
   output reg  si
);
   initial begin
      csN  = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end
   task automatic start;
      @(negedge clk);
      csN = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   // MSB first; so is taken as sclk rises, long after its fall
   task automatic xfer(input logic [31:0] v, input int n,
                       output logic [7:0] b);
      b = 8'h00;
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b0;
         si   = v[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         b    = {b[6:0], so};
         repeat (4) @(negedge clk);
      end
   endtask
   // May end mid-byte; idle si flips so no stale bit looks valid
   task automatic stop;
      sclk = 1'b0;
      repeat (4) @(negedge clk);
      csN = 1'b1;
      si  = ~si;
      repeat (6) @(negedge clk);
   endtask
endmodule

/* File: testbench/spl_sector_lock_tb_top.sv */
`timescale 1ns/1ps
`include "spl_map.vh"
// ----------------------------------------
// Corner and random command mix
// ----------------------------------------
module spl_sector_lock_tb_top;
   logic        clk, rst_n, wpN, csN, sclk, si, so, soOe;
   logic        protLockBit, hwLocked, swLocked, expLock;
   logic [3:0]  sectorProtect, expProt;
   logic [1:0]  sectorProtectSummary;
   logic [7:0]  rdByte;
   int          error_cnt, n_compared;
   // Entries are {wpN, cut, opcode, data}
   logic [17:0] corner [13] = '{18'h20100, 18'h03600, 18'h23900,
      18'h33600, 18'h201FF, 18'h23900, 18'h20100, 18'h00180, 18'h0017F,
      18'h03600, 18'h20100, 18'h2017F, 18'h201F0};
   logic [7:0]  ops [3] = '{`SPL_OP_PROT_SECT, `SPL_OP_UNPROT_SECT,
      `SPL_OP_WR_STATUS};

   spl_sector_lock i_spl_sector_lock (
      .clk(clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .si(si),
      .wpN(wpN), .so(so), .soOe(soOe), .protLockBit(protLockBit),
      .sectorProtect(sectorProtect),
      .sectorProtectSummary(sectorProtectSummary),
      .hwLocked(hwLocked), .swLocked(swLocked));
   spl_spi_host i_spl_spi_host (
      // Undriven line reads high, as a pull-up would
      .clk(clk), .so(soOe ? so : 1'b1), .csN(csN), .sclk(sclk), .si(si));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Decisions use the lock value from before the write
   function automatic logic [4:0] nextState(input logic [4:0] st,
      input logic wp, input logic [7:0] op, input logic [7:0] d,
      input logic [1:0] sec);
      logic [3:0] p;
      logic       lk;
      {lk, p} = st;
      if (op == `SPL_OP_WR_STATUS && (wp || !lk)) begin
         if (!lk && d[5:2] == `SPL_GLOB_CLEAR) p = 4'h0;
         if (!lk && d[5:2] == `SPL_GLOB_SET) p = 4'hF;
         lk = d[`SPL_ST_LOCK_BIT];
      end
      if (!lk && op == `SPL_OP_PROT_SECT) p[sec] = 1'b1;
      if (!lk && op == `SPL_OP_UNPROT_SECT) p[sec] = 1'b0;
      return {lk, p};
   endfunction
   task automatic doStep(input logic wp, input logic [7:0] op,
                         input logic [7:0] d, input logic cut);
      logic [1:0]  sec;
      logic [23:0] adr;
      logic [31:0] frame;
      logic [7:0]  expSt;
      int          n;
      sec = 2'($urandom);
      adr = {6'h00, sec, 16'($urandom)};
      n   = (op == `SPL_OP_WR_STATUS) ? 16 : 32;
      frame = (n == 16) ? {16'h0000, op, d} : {op, adr};
      wpN = wp;
      repeat (6) @(negedge clk);
      i_spl_spi_host.start();
      // A cut frame keeps its head and drops its last four bits
      i_spl_spi_host.xfer(cut ? frame >> 4 : frame,
                          cut ? n - 4 : n, rdByte);
      i_spl_spi_host.stop();
      if (!cut)
         {expLock, expProt} = nextState({expLock, expProt}, wp, op, d, sec);
      check({3'h0, protLockBit, sectorProtect},
            {3'h0, expLock, expProt});
      check({6'h00, hwLocked, swLocked},
            {6'h00, !wp & expLock, wp & expLock});
      check({6'h00, sectorProtectSummary},
            {6'h00, &expProt, |expProt});
      adr[15:0] = 16'($urandom);
      i_spl_spi_host.start();
      i_spl_spi_host.xfer({`SPL_OP_RD_PROT, adr}, 32, rdByte);
      i_spl_spi_host.xfer(32'($urandom), 8, rdByte);
      check(rdByte, {8{expProt[sec]}});
      i_spl_spi_host.xfer(32'($urandom), 3, rdByte);
      check(rdByte, {5'h00, {3{expProt[sec]}}});
      i_spl_spi_host.stop();
      // Status read, two bytes to cover the per-byte refresh
      expSt = {expLock, 1'h0, &expProt, |expProt, wp, 3'h0};
      i_spl_spi_host.start();
      i_spl_spi_host.xfer({24'h000000, `SPL_OP_RD_STATUS}, 8, rdByte);
      repeat (2) begin
         i_spl_spi_host.xfer(32'($urandom), 8, rdByte);
         check(rdByte, expSt);
      end
      i_spl_spi_host.stop();
   endtask
   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      error_cnt  = 0;
      n_compared = 0;
      rst_n      = 1'b0;
      wpN        = 1'b1;
      {expLock, expProt} = {`SPL_RST_LOCK, `SPL_RST_PROT};
      void'($urandom(32'h56B357BF));
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check({3'h0, protLockBit, sectorProtect}, 8'h0F);
      foreach (corner[k])
         doStep(corner[k][17], corner[k][15:8], corner[k][7:0], corner[k][16]);
      $display("corner test done");
      repeat (40)
         doStep(1'($urandom), ops[$urandom % 3], 8'($urandom),
                $urandom % 5 == 0);
      $display("random test done");
      report_and_stop();
   end
   // Nearly twice the expected run length
   initial begin
      #1600000;
      error_cnt++;
      report_and_stop();
   end
endmodule

bind spl_sector_lock spl_sector_lock_assertions i_spl_sector_lock_assertions (
   .clk(clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .si(si), .wpN(wpN),
   .so(so), .soOe(soOe), .protLockBit(protLockBit),
   .sectorProtect(sectorProtect), .sectorProtectSummary(sectorProtectSummary),
   .hwLocked(hwLocked), .swLocked(swLocked));
